//--- verilog/dwm_pkg.sv
package dwm_pkg;
    // --------------------------------------------------------------------
    // Data path geometry
    // --------------------------------------------------------------------
    localparam int LANES      = 16;
    localparam int WORD_BITS  = 16;
    localparam int SYM_PER_CK = 8;
    localparam int BYTE_BITS  = 8;
    localparam int BYTES      = 2 * LANES;
    localparam int SC_BITS    = 4;
    localparam int WIDTH_BITS = 3;

    // --------------------------------------------------------------------
    // Device width field codes
    // --------------------------------------------------------------------
    localparam logic [2:0] WIDTH_X1  = 3'h0;
    localparam logic [2:0] WIDTH_X2  = 3'h1;
    localparam logic [2:0] WIDTH_X4  = 3'h2;
    localparam logic [2:0] WIDTH_X8  = 3'h3;
    localparam logic [2:0] WIDTH_X16 = 3'h4;

    // Serial write data order: slot k of the lane 0 pin carries data bit
    // SER_BIT_ORDER[k]; slot 0 is field bit 7 of byte 1.
    localparam logic [63:0] SER_BIT_ORDER = 64'h0_4_8_c_1_5_9_d_2_6_a_e_3_7_b_f;

    // --------------------------------------------------------------------
    // Link timing
    // --------------------------------------------------------------------
    localparam int SYS_CLK_NS    = 100;
    localparam int LINK_HALF_CYC = 4;

    typedef enum logic [1:0] {
        DWM_IDLE = 2'b00,
        DWM_CYC0 = 2'b01,
        DWM_CYC1 = 2'b10
    } dwm_phase_type;

    // Lane count from width code; undefined codes fall back to one lane.
    function automatic logic [4:0] dwm_lanes(input logic [2:0] w);
        case (w)
            WIDTH_X2:  dwm_lanes = 5'h02;
            WIDTH_X4:  dwm_lanes = 5'h04;
            WIDTH_X8:  dwm_lanes = 5'h08;
            WIDTH_X16: dwm_lanes = 5'h10;
            default:   dwm_lanes = 5'h01;
        endcase
    endfunction

    // First core set routed for a given width and sub-column select.
    function automatic logic [3:0] dwm_base(input logic [2:0] w, input logic [3:0] sc);
        case (w)
            WIDTH_X2:  dwm_base = {sc[3:1], 1'b0};
            WIDTH_X4:  dwm_base = {sc[3:2], 2'h0};
            WIDTH_X8:  dwm_base = {sc[3], 3'h0};
            WIDTH_X16: dwm_base = 4'h0;
            default:   dwm_base = sc;
        endcase
    endfunction
endpackage

//--- verilog/dwm_link_if.sv
`timescale 1ns/1ps
`default_nettype none
interface dwm_link_if;
    import dwm_pkg::*;
    logic                    master_clock;
    logic                    frame;
    logic [LANES-1:0]        dq_ctl;
    logic [LANES-1:0]        dq_dev;
    logic [LANES-1:0]        dq_ctl_oe;
    logic [LANES-1:0]        dq_dev_oe;
    logic                    write_cmd;
    logic                    masked_write_command;
    logic [SC_BITS-1:0]      subcolumn_select;
    logic [BYTE_BITS-1:0]    mask_value;
    logic                    serial_write_data_format;
    logic [LANES-1:0]        dq;

    // Wire level: whichever side drives wins; an undriven pin idles low
    assign dq = (dq_ctl & dq_ctl_oe) | (dq_dev & dq_dev_oe);

    modport ctl (
        output master_clock, frame, dq_ctl, dq_ctl_oe, write_cmd,
               masked_write_command, subcolumn_select, mask_value,
               serial_write_data_format,
        input  dq
    );
    modport dev (
        input  master_clock, frame, write_cmd, masked_write_command,
               subcolumn_select, mask_value, serial_write_data_format, dq,
        output dq_dev, dq_dev_oe
    );
endinterface
`default_nettype wire

//--- verilog/dwm_width_map.sv
`timescale 1ns/1ps
`default_nettype none
module dwm_width_map
    import dwm_pkg::*;
(
    input  wire logic [2:0]                         width_code,
    input  wire logic [SC_BITS-1:0]                 sc,
    input  wire logic [LANES-1:0][WORD_BITS-1:0]    core_rd,
    input  wire logic [LANES-1:0][WORD_BITS-1:0]    lane_wr,
    output logic      [LANES-1:0][WORD_BITS-1:0]    lane_rd,
    output logic      [LANES-1:0][WORD_BITS-1:0]    core_wr,
    output logic      [LANES-1:0]                   core_sel,
    output logic      [LANES-1:0]                   lane_used
);
    logic [4:0] n;
    logic [3:0] b;
    assign n = dwm_lanes(width_code);
    assign b = dwm_base(width_code, sc);

    // Parallel words, between deserialiser and serialiser
    genvar i;
    for (i = 0; i < LANES; i++) begin : g_lane
        logic [3:0] src;
        logic [3:0] lane_of;
        assign src       = 4'(b + 4'(i));
        assign lane_of   = 4'(4'(i) - b);
        assign lane_used[i] = (5'(i) < n);
        assign lane_rd[i]   = lane_used[i] ? core_rd[src] : '0;
        assign core_sel[i]  = (4'(i) >= b) && (5'(4'(i) - b) < n);
        assign core_wr[i]   = core_sel[i] ? lane_wr[lane_of] : '0;
    end
endmodule
`default_nettype wire

//--- verilog/dwm_device.sv
`timescale 1ns/1ps
`default_nettype none
module dwm_device
    import dwm_pkg::*;
(
    input  wire logic                               sys_clk,
    input  wire logic                               rst,
    dwm_link_if.dev                                 link,
    input  wire logic [2:0]                         width_code,
    input  wire logic [LANES-1:0][WORD_BITS-1:0]    core_rd_data,
    output logic                                    rd_take,
    output logic      [LANES-1:0][WORD_BITS-1:0]    core_wr_data,
    output logic      [BYTES-1:0]                   core_byte_we,
    output logic                                    core_wr_valid,
    output logic      [WORD_BITS-1:0]               serial_word,
    output logic                                    serial_word_valid
);
    // --------------------------------------------------------------------
    // Synchronisers
    // --------------------------------------------------------------------
    logic             clk_s1_ff, clk_s2_ff, clk_d_ff;
    logic [3:0]       ctl_s1_ff, ctl_s2_ff;
    logic [LANES-1:0] dq_s1_ff, dq_s2_ff;
    logic [3:0]       sc_s1_ff, sc_s2_ff;
    logic [7:0]       m_s1_ff, m_s2_ff;

    always_ff @(posedge sys_clk) begin
        if (rst) begin
            clk_s1_ff <= '0; clk_s2_ff <= '0; clk_d_ff <= '0;
            ctl_s1_ff <= '0; ctl_s2_ff <= '0;
            dq_s1_ff  <= '0; dq_s2_ff  <= '0;
            sc_s1_ff  <= '0; sc_s2_ff  <= '0;
            m_s1_ff   <= '0; m_s2_ff   <= '0;
        end else begin
            clk_s1_ff <= link.master_clock;
            clk_s2_ff <= clk_s1_ff;
            clk_d_ff  <= clk_s2_ff;
            ctl_s1_ff <= {link.frame, link.write_cmd, link.masked_write_command,
                          link.serial_write_data_format};
            ctl_s2_ff <= ctl_s1_ff;
            dq_s1_ff  <= link.dq;
            dq_s2_ff  <= dq_s1_ff;
            sc_s1_ff  <= link.subcolumn_select;
            sc_s2_ff  <= sc_s1_ff;
            m_s1_ff   <= link.mask_value;
            m_s2_ff   <= m_s1_ff;
        end
    end

    logic rise, fall, frame_s, wr_s, wrm_s, ser_s;
    assign rise    = clk_s2_ff & ~clk_d_ff;
    assign fall    = ~clk_s2_ff & clk_d_ff;
    assign frame_s = ctl_s2_ff[3];
    assign wr_s    = ctl_s2_ff[2];
    assign wrm_s   = ctl_s2_ff[1];
    assign ser_s   = ctl_s2_ff[0];

    // --------------------------------------------------------------------
    // Symbol sequencer: one symbol per link clock edge, 16 per packet
    // --------------------------------------------------------------------
    dwm_phase_type phase_ff, nxt_phase;
    logic [3:0]    sym_ff, nxt_sym;
    logic          dir_wr_ff, nxt_dir_wr, mask_ff, nxt_mask, ser_ff, nxt_ser;
    logic [3:0]    sc_ff, nxt_sc;
    logic [7:0]    m_ff, nxt_m;
    logic [LANES-1:0][WORD_BITS-1:0] shreg_ff, nxt_shreg;
    logic          done, edge_any;

    assign edge_any = rise | fall;
    assign done     = edge_any && (sym_ff == 4'hf) && (phase_ff == DWM_CYC1);

    always_comb begin
        nxt_phase  = phase_ff;
        nxt_sym    = sym_ff;
        nxt_dir_wr = dir_wr_ff;
        nxt_mask   = mask_ff;
        nxt_ser    = ser_ff;
        nxt_sc     = sc_ff;
        nxt_m      = m_ff;
        nxt_shreg  = shreg_ff;
        case (phase_ff)
            DWM_IDLE: begin
                if (frame_s && rise) begin
                    nxt_phase  = DWM_CYC0;
                    nxt_sym    = 4'h1;
                    nxt_dir_wr = wr_s | wrm_s;
                    nxt_mask   = wrm_s;
                    nxt_ser    = ser_s;
                    nxt_sc     = sc_s2_ff;
                    nxt_m      = m_s2_ff;
                    // Symbol 0 is already on the pins at the opening edge
                    for (int l = 0; l < LANES; l++) begin
                        nxt_shreg[l] = {dq_s2_ff[l], shreg_ff[l][WORD_BITS-1:1]};
                    end
                end
            end
            DWM_CYC0, DWM_CYC1: begin
                if (edge_any) begin
                    // Bit t of each lane word arrives in symbol time t
                    for (int l = 0; l < LANES; l++) begin
                        nxt_shreg[l] = {dq_s2_ff[l], shreg_ff[l][WORD_BITS-1:1]};
                    end
                    nxt_sym = 4'(sym_ff + 4'h1);
                    if (sym_ff == 4'h7) begin
                        nxt_phase = DWM_CYC1;
                    end
                    if (done) begin
                        nxt_phase = DWM_IDLE;
                    end
                end
            end
            default: nxt_phase = DWM_IDLE;
        endcase
    end

    always_ff @(posedge sys_clk) begin
        if (rst) begin
            phase_ff  <= DWM_IDLE;
            sym_ff    <= '0;
            dir_wr_ff <= 1'b0;
            mask_ff   <= 1'b0;
            ser_ff    <= 1'b0;
            sc_ff     <= '0;
            m_ff      <= '0;
            shreg_ff  <= '0;
        end else begin
            phase_ff  <= nxt_phase;
            sym_ff    <= nxt_sym;
            dir_wr_ff <= nxt_dir_wr;
            mask_ff   <= nxt_mask;
            ser_ff    <= nxt_ser;
            sc_ff     <= nxt_sc;
            m_ff      <= nxt_m;
            shreg_ff  <= nxt_shreg;
        end
    end

    // --------------------------------------------------------------------
    // Width mapping
    // --------------------------------------------------------------------
    logic [LANES-1:0][WORD_BITS-1:0] lane_rd, core_wr, rd_hold_ff, nxt_rd_hold;
    logic [LANES-1:0]                core_sel, lane_used;

    dwm_width_map u_map (
        .width_code (width_code),
        .sc         (phase_ff == DWM_IDLE ? sc_s2_ff : sc_ff),
        .core_rd    (core_rd_data),
        .lane_wr    (nxt_shreg),
        .lane_rd    (lane_rd),
        .core_wr    (core_wr),
        .core_sel   (core_sel),
        .lane_used  (lane_used)
    );

    // --------------------------------------------------------------------
    // Write commit, byte mask and read drive
    // --------------------------------------------------------------------
    logic [LANES-1:0][WORD_BITS-1:0] wr_data_ff, nxt_wr_data;
    logic [BYTES-1:0]                we_ff, nxt_we;
    logic                            wv_ff, nxt_wv, sv_ff, nxt_sv, take;
    logic [WORD_BITS-1:0]            sw_ff, nxt_sw;
    logic [LANES-1:0]                oe_ff, nxt_oe;

    assign take = (phase_ff == DWM_IDLE) && frame_s && rise && !(wr_s | wrm_s);

    always_comb begin
        nxt_wr_data = wr_data_ff;
        nxt_we      = '0;
        nxt_wv      = 1'b0;
        nxt_sv      = 1'b0;
        nxt_sw      = sw_ff;
        nxt_rd_hold = take ? lane_rd : rd_hold_ff;
        nxt_oe      = oe_ff;
        if (take) begin
            nxt_oe = lane_used;
        end else if (phase_ff == DWM_IDLE && edge_any) begin
            // Last read symbol stands one link edge past the end of the packet
            nxt_oe = '0;
        end
        if (done && dir_wr_ff) begin
            nxt_wr_data = core_wr;
            nxt_wv      = 1'b1;
            for (int k = 0; k < BYTES; k++) begin
                // Masked write: byte equal to mask is not written
                nxt_we[k] = core_sel[k/2] &&
                    (!mask_ff || (core_wr[k/2][(k%2)*8 +: 8] != m_ff));
            end
            if (ser_ff) begin
                // Reassemble lane 0 word from the interleaved serial stream
                nxt_sv = 1'b1;
                for (int k = 0; k < WORD_BITS; k++) begin
                    nxt_sw[SER_BIT_ORDER[k*4 +: 4]] = nxt_shreg[0][k];
                end
            end
        end
    end

    always_ff @(posedge sys_clk) begin
        if (rst) begin
            wr_data_ff <= '0;
            we_ff      <= '0;
            wv_ff      <= 1'b0;
            sv_ff      <= 1'b0;
            sw_ff      <= '0;
            rd_hold_ff <= '0;
            oe_ff      <= '0;
        end else begin
            wr_data_ff <= nxt_wr_data;
            we_ff      <= nxt_we;
            wv_ff      <= nxt_wv;
            sv_ff      <= nxt_sv;
            sw_ff      <= nxt_sw;
            rd_hold_ff <= nxt_rd_hold;
            oe_ff      <= nxt_oe;
        end
    end

    // Read pins: symbol counter selects the bit of the held word
    for (genvar l = 0; l < LANES; l++) begin : g_drv
        assign link.dq_dev[l] = rd_hold_ff[l][4'(sym_ff - 4'h1)];
    end
    assign link.dq_dev_oe    = oe_ff;
    assign rd_take           = take;
    assign core_wr_data      = wr_data_ff;
    assign core_byte_we      = we_ff;
    assign core_wr_valid     = wv_ff;
    assign serial_word       = sw_ff;
    assign serial_word_valid = sv_ff;
endmodule
`default_nettype wire

//--- verilog/dwm_controller.sv
`timescale 1ns/1ps
`default_nettype none
module dwm_controller
    import dwm_pkg::*;
(
    input  wire logic                               sys_clk,
    input  wire logic                               rst,
    dwm_link_if.ctl                                 link,
    input  wire logic                               req_valid,
    input  wire logic                               req_write,
    input  wire logic                               req_masked,
    input  wire logic                               req_serial,
    input  wire logic [SC_BITS-1:0]                 req_sc,
    input  wire logic [BYTE_BITS-1:0]               req_mask,
    input  wire logic [LANES-1:0][WORD_BITS-1:0]    req_wdata,
    output logic                                    req_ready,
    output logic      [LANES-1:0][WORD_BITS-1:0]    rd_data,
    output logic                                    rd_valid
);
    // Link clock: divided from sys_clk, 8 sys_clk cycles per period
    logic [2:0] div_ff, nxt_div;
    logic [4:0] sym_ff, nxt_sym;
    logic       busy_ff, nxt_busy, wr_ff, nxt_wr, wrm_ff, nxt_wrm, ser_ff, nxt_ser, rv_ff, nxt_rv;
    logic [3:0] sc_ff, nxt_sc;
    logic [7:0] m_ff, nxt_m;
    logic [LANES-1:0][WORD_BITS-1:0] wd_ff, nxt_wd, rd_ff, nxt_rd;
    logic [LANES-1:0] dqs1_ff, dqs2_ff;
    logic       tick;

    assign tick = (div_ff == 3'(LINK_HALF_CYC - 1)) || (div_ff == 3'(2*LINK_HALF_CYC - 1));

    always_comb begin
        nxt_div  = 3'(div_ff + 3'h1);
        nxt_sym  = sym_ff;
        nxt_busy = busy_ff;
        nxt_wr   = wr_ff;
        nxt_wrm  = wrm_ff;
        nxt_ser  = ser_ff;
        nxt_sc   = sc_ff;
        nxt_m    = m_ff;
        nxt_wd   = wd_ff;
        nxt_rd   = rd_ff;
        nxt_rv   = 1'b0;
        if (!busy_ff && req_valid && div_ff == 3'h0) begin
            nxt_busy = 1'b1;
            nxt_sym  = '0;
            nxt_wr   = req_write;
            nxt_wrm  = req_write & req_masked;
            nxt_ser  = req_serial;
            nxt_sc   = req_sc;
            nxt_m    = req_mask;
            nxt_wd   = req_wdata;
        end else if (busy_ff && tick) begin
            // Synchronisers on both ends put the read answer two symbols behind
            for (int l = 0; l < LANES; l++) begin
                nxt_rd[l][4'(sym_ff - 5'h2)] = dqs2_ff[l];
            end
            nxt_sym = 5'(sym_ff + 5'h1);
            if (sym_ff == 5'h11) begin
                nxt_busy = 1'b0;
                nxt_rv   = !wr_ff;
            end
        end
    end

    always_ff @(posedge sys_clk) begin
        if (rst) begin
            div_ff <= '0; sym_ff <= '0; busy_ff <= 1'b0; wr_ff <= 1'b0;
            wrm_ff <= 1'b0; ser_ff <= 1'b0; sc_ff <= '0; m_ff <= '0;
            wd_ff <= '0; rd_ff <= '0; rv_ff <= 1'b0; dqs1_ff <= '0; dqs2_ff <= '0;
        end else begin
            div_ff <= nxt_div; sym_ff <= nxt_sym; busy_ff <= nxt_busy; wr_ff <= nxt_wr;
            wrm_ff <= nxt_wrm; ser_ff <= nxt_ser; sc_ff <= nxt_sc; m_ff <= nxt_m;
            wd_ff <= nxt_wd; rd_ff <= nxt_rd; rv_ff <= nxt_rv;
            dqs1_ff <= link.dq; dqs2_ff <= dqs1_ff;
        end
    end

    // Write words go out bit 0 first; lane 0 carries the serial order when asked
    logic [3:0] bsel;
    assign bsel = sym_ff[3:0] - 4'h1;
    always_comb begin
        for (int l = 0; l < LANES; l++) begin
            link.dq_ctl[l] = wd_ff[l][bsel];
        end
        if (ser_ff) begin
            link.dq_ctl[0] = wd_ff[0][SER_BIT_ORDER[{bsel, 2'b00} +: 4]];
        end
    end

    assign link.master_clock = div_ff[2];
    // Frame covers the link high phase of symbol 0, so the device sees both together
    assign link.frame        = busy_ff && sym_ff == 5'h1;
    assign link.dq_ctl_oe    = {LANES{busy_ff && wr_ff && sym_ff != 5'h0}};
    assign link.write_cmd    = wr_ff & ~wrm_ff;
    assign link.masked_write_command = wrm_ff;
    assign link.subcolumn_select     = sc_ff;
    assign link.mask_value           = m_ff;
    assign link.serial_write_data_format = ser_ff;
    assign req_ready = !busy_ff && div_ff == 3'h0;
    assign rd_data   = rd_ff;
    assign rd_valid  = rv_ff;
endmodule
`default_nettype wire

//--- sim/dwm_link_monitor.sv
`timescale 1ns/1ps
`default_nettype none
module dwm_link_monitor
    import dwm_pkg::*;
(
    input wire logic             sys_clk,
    input wire logic             rst,
    input wire logic [2:0]       width_code,
    input wire logic             master_clock,
    input wire logic             frame,
    input wire logic             write_cmd,
    input wire logic             masked_write_command,
    input wire logic             serial_write_data_format,
    input wire logic [LANES-1:0] dq_ctl_oe,
    input wire logic [LANES-1:0] dq_dev_oe
);
    // ----------------------------------------------------------------
    // Pins a device of the current width may drive
    // ----------------------------------------------------------------
    logic [LANES-1:0] pins_ok;

    always_comb begin
        case (width_code)
            3'h1:    pins_ok = 16'h0003;
            3'h2:    pins_ok = 16'h000f;
            3'h3:    pins_ok = 16'h00ff;
            3'h4:    pins_ok = 16'hffff;
            default: pins_ok = 16'h0001;
        endcase
    end

    // ----------------------------------------------------------------
    // Link properties
    // ----------------------------------------------------------------
    default clocking @(posedge sys_clk); endclocking
    default disable iff (rst);

    property p_pins_excl;
        (dq_ctl_oe & dq_dev_oe) == 16'h0000;
    endproperty
    a_pins_excl: assert property (p_pins_excl)
        else $error("both ends drive one pin");
    property p_dev_narrow;
        (dq_dev_oe & ~pins_ok) == 16'h0000;
    endproperty
    a_dev_narrow: assert property (p_dev_narrow)
        else $error("device drives a pin above its width");
    property p_frame_short;
        $rose(frame) |-> ##[1:8] !frame;
    endproperty
    a_frame_short: assert property (p_frame_short)
        else $error("frame marker too long");
    property p_link_half;
        $rose(master_clock) |-> master_clock [*4] ##1 !master_clock;
    endproperty
    a_link_half: assert property (p_link_half)
        else $error("link clock high phase not four cycles");
    property p_write_driven;
        $rose(frame) && (write_cmd || masked_write_command) |-> ##[0:8] (dq_ctl_oe != 16'h0000);
    endproperty
    a_write_driven: assert property (p_write_driven)
        else $error("write packet without data drive");
    property p_read_ctl_quiet;
        frame && !write_cmd && !masked_write_command |-> dq_ctl_oe == 16'h0000;
    endproperty
    a_read_ctl_quiet: assert property (p_read_ctl_quiet)
        else $error("controller drives during read");
    property p_read_dev_drives;
        $rose(frame) && !write_cmd && !masked_write_command |-> ##[1:16] (dq_dev_oe != 16'h0000);
    endproperty
    a_read_dev_drives: assert property (p_read_dev_drives)
        else $error("device silent on read");
    property p_write_dev_quiet;
        frame && (write_cmd || masked_write_command) |-> dq_dev_oe == 16'h0000;
    endproperty
    a_write_dev_quiet: assert property (p_write_dev_quiet)
        else $error("device drives during write");

    c_masked: cover property ($rose(frame) && masked_write_command);
    c_serial: cover property ($rose(frame) && serial_write_data_format);
    c_read:   cover property ($rose(frame) && !write_cmd && !masked_write_command);
endmodule
`default_nettype wire

//--- sim/dram_width_mux_byte_mask_tb_top.sv
`timescale 1ns/1ps
`default_nettype none
module dram_width_mux_byte_mask_tb_top
    import dwm_pkg::*;
;
    logic                 sys_clk, rst, rd_take, core_wr_valid, serial_word_valid, took;
    logic                 req_valid, req_write, req_masked, req_serial, req_ready, rd_valid;
    logic [2:0]           width_code, wcode;
    logic [SC_BITS-1:0]   req_sc;
    logic [BYTE_BITS-1:0] req_mask, mk;
    logic [BYTES-1:0]     core_byte_we, exp_we, we_seen;
    logic [WORD_BITS-1:0] serial_word, wire_bits, exp_bits;
    logic [LANES-1:0][WORD_BITS-1:0] core_rd_data, core_wr_data, req_wdata, rd_data, wbuf, rbuf;
    int                   err_count, samples_checked;
    localparam int ORD[16] = '{15, 11, 7, 3, 14, 10, 6, 2, 13, 9, 5, 1, 12, 8, 4, 0};

    dwm_link_if dwm_link_if_inst ();
    dwm_device dwm_device_inst (.sys_clk(sys_clk), .rst(rst), .link(dwm_link_if_inst),
        .width_code(width_code), .core_rd_data(core_rd_data), .rd_take(rd_take),
        .core_wr_data(core_wr_data), .core_byte_we(core_byte_we),
        .core_wr_valid(core_wr_valid), .serial_word(serial_word),
        .serial_word_valid(serial_word_valid));
    dwm_controller dwm_controller_inst (.sys_clk(sys_clk), .rst(rst),
        .link(dwm_link_if_inst), .req_valid(req_valid), .req_write(req_write),
        .req_masked(req_masked), .req_serial(req_serial), .req_sc(req_sc),
        .req_mask(req_mask), .req_wdata(req_wdata), .req_ready(req_ready),
        .rd_data(rd_data), .rd_valid(rd_valid));
    dwm_link_monitor dwm_link_monitor_inst (.sys_clk(sys_clk), .rst(rst),
        .width_code(width_code), .master_clock(dwm_link_if_inst.master_clock),
        .frame(dwm_link_if_inst.frame), .write_cmd(dwm_link_if_inst.write_cmd),
        .masked_write_command(dwm_link_if_inst.masked_write_command),
        .serial_write_data_format(dwm_link_if_inst.serial_write_data_format),
        .dq_ctl_oe(dwm_link_if_inst.dq_ctl_oe), .dq_dev_oe(dwm_link_if_inst.dq_dev_oe));

    initial begin
        sys_clk = 1'b0;
        forever #50 sys_clk = ~sys_clk;
    end

    // ----------------------------------------------------------------
    // Transfer tasks
    // ----------------------------------------------------------------
    task automatic end_of_test();
        $display("mismatches %0d, comparisons %0d", err_count, samples_checked);
        if (err_count == 0 && samples_checked > 0) begin
            $display("Regression OK");
        end else begin
            $display("Regression broken");
        end
        $finish;
    endtask

    task automatic check(input logic [255:0] seen, input logic [255:0] exp);
        samples_checked++;
        if (seen !== exp) begin
            err_count++;
            $display("unexpected at %0t: seen %h expected %h", $time, seen, exp);
        end
    endtask

    task automatic hang();
        err_count++;
        end_of_test();
    endtask

    task automatic send(input logic wr, ms, ser, input logic [3:0] sc, input logic [7:0] m);
        int i;
        @(posedge sys_clk);
        width_code <= wcode;
        core_rd_data <= rbuf;
        req_wdata <= wbuf;
        req_valid <= 1'b1;
        req_write <= wr;
        req_masked <= ms;
        req_serial <= ser;
        req_sc <= sc;
        req_mask <= m;
        // Ready is combinational, so judge it at the falling edge where it has settled
        for (i = 0; i < 300; i++) begin
            @(negedge sys_clk);
            if (req_ready === 1'b1) break;
        end
        if (i == 300) hang();
        @(posedge sys_clk);
        req_valid <= 1'b0;
    endtask

    // Write enables are a one-cycle pulse, so they are latched at the completion cycle
    task automatic await(input int which);
        int i;
        for (i = 0; i < 400; i++) begin
            @(posedge sys_clk);
            #1;
            we_seen = core_byte_we;
            took = took | (rd_take === 1'b1);
            if (which == 0 && core_wr_valid === 1'b1) break;
            if (which == 1 && rd_valid === 1'b1) break;
            if (which == 2 && serial_word_valid === 1'b1) break;
        end
        if (i == 400) hang();
    endtask

    // Sample mid-symbol so a small skew on either end cannot shift a bit
    task automatic grab();
        int i;
        for (i = 0; i < 300; i++) begin
            @(posedge sys_clk);
            #1;
            if (dwm_link_if_inst.frame === 1'b1) break;
        end
        if (i == 300) hang();
        #150;
        for (i = 0; i < 16; i++) begin
            wire_bits[i] = dwm_link_if_inst.dq[0];
            #400;
        end
    endtask

    task automatic wr(input logic ms, ser, input logic [3:0] sc, input logic [7:0] m);
        int k;
        fork
            send(1'b1, ms, ser, sc, m);
            grab();
            await(ser ? 2 : 0);
        join
        for (k = 0; k < 16; k++) begin
            exp_bits[k] = ser ? wbuf[0][ORD[k]] : wbuf[0][k];
        end
        check(wire_bits, exp_bits);
    endtask

    // ----------------------------------------------------------------
    // Main sequence
    // ----------------------------------------------------------------
    initial begin
        int w, s, i, n, b, m;
        rst = 1'b1;
        {req_valid, req_write, req_masked, req_serial} = 4'h0;
        req_sc = 4'h0;
        req_mask = 8'h00;
        wcode = 3'h4;
        width_code = 3'h4;
        wbuf = '0;
        rbuf = '0;
        req_wdata = '0;
        core_rd_data = '0;
        err_count = 0;
        samples_checked = 0;
        repeat (8) @(posedge sys_clk);
        rst <= 1'b0;
        for (w = 0; w < 5; w++) begin
            for (s = 0; s < 16; s += 5) begin
                n = 1 << w;
                b = s & ~(n - 1);
                wcode = 3'(w);
                for (i = 0; i < 16; i++) begin
                    wbuf[i] = 16'(i * 16'h1111 + w * 16'h0203 + s * 16'h0041);
                    rbuf[i] = ~wbuf[i] ^ 16'h3c00;
                    exp_we[2*i +: 2] = (i >= b && i < b + n) ? 2'b11 : 2'b00;
                end
                // Mask equal to a data byte must not matter on a plain write
                wr(1'b0, 1'b0, 4'(s), wbuf[0][7:0]);
                check(we_seen, exp_we);
                for (i = 0; i < n; i++) begin
                    check(core_wr_data[b + i], wbuf[i]);
                end
                took = 1'b0;
                fork
                    send(1'b0, 1'b0, 1'b0, 4'(s), 8'h00);
                    await(1);
                join
                check(took, 1'b1);
                for (i = 0; i < 16; i++) begin
                    check(rd_data[i], i < n ? rbuf[b + i] : 16'h0000);
                end
            end
        end
        wcode = 3'h4;
        for (m = 0; m < 2; m++) begin
            mk = m ? 8'h85 : 8'h5a;
            for (i = 0; i < 16; i++) begin
                wbuf[i] = 16'(16'h0101 * i + 16'h8001);
            end
            wbuf[3][15:8] = 8'h5a;
            wbuf[9][7:0] = 8'h5a;
            wbuf[15][15:8] = 8'h5a;
            for (i = 0; i < 32; i++) begin
                exp_we[i] = wbuf[i/2][(i%2)*8 +: 8] != mk;
            end
            wr(1'b1, 1'b0, 4'h9, mk);
            check(we_seen, exp_we);
        end
        wbuf[0] = 16'h9a3c;
        wr(1'b0, 1'b1, 4'h0, 8'h00);
        check(serial_word, wbuf[0]);
        end_of_test();
    end
endmodule
`default_nettype wire
